//--- include/pml_params.svh
`ifndef PML_PARAMS_SVH
`define PML_PARAMS_SVH
// =====================================
// Register address width and offsets
`define PML_ADDR_W       4
`define PML_REG_STATUS   4'h0
`define PML_REG_KEYSEL   4'h4
// Status field positions
`define PML_ST_LEVEL_LO  0
`define PML_ST_EA_BIT    2
`define PML_ST_ENC_BIT   3
`define PML_ST_UNDEF_BIT 4
// Reset values and key index width
`define PML_KEYSEL_RST   8'h00
`define PML_KEY_W        6
`endif

//--- include/pml_pkg.sv
package pml_pkg;
	// Protection levels, one per defined lock combination
	typedef enum logic [1:0] {
		PML_LVL_OPEN,
		PML_LVL_ONE,
		PML_LVL_TWO,
		PML_LVL_THREE
	} pml_level_e;

	// Start-up sequence: fill pin synchroniser, capture, run
	typedef enum logic [1:0] {
		PML_SYNC,
		PML_SETTLE,
		PML_SAMPLE,
		PML_RUN
	} pml_phase_e;

	// Grant outputs toward programmer and core
	typedef struct packed {
		logic verify_ok;
		logic program_ok;
		logic table_read_ok;
		logic ext_exec_ok;
		logic ea_eff;
		logic [7:0] verify_data;
	} pml_grant_s;

	// Whole module state
	typedef struct packed {
		pml_phase_e phase;
		pml_level_e level;
		logic       undefined;
		logic       enc_on;
		logic       ea_lat;
		logic [1:0] ea_sync;
		logic [7:0] keysel;
		logic [7:0] rdata;
		pml_grant_s grant;
	} pml_state_s;
endpackage

//--- design/pml_lock.sv
`timescale 1ns/1ps
`include "pml_params.svh"
module pml_lock
	import pml_pkg::*;
#(
	parameter int KEY_DEPTH = 64
) (
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire logic                    lock_bit_one,
	input  wire logic                    lock_bit_two,
	input  wire logic                    lock_bit_three,
	input  wire logic                    enc_programmed,
	input  wire logic                    external_access_select,
	input  wire logic                    fetch_external,
	input  wire logic [7:0]              prog_byte,
	input  wire logic [`PML_KEY_W-1:0]   key_index,
	input  wire logic [7:0]              key_byte,
	input  wire logic [`PML_ADDR_W-1:0]  addr,
	input  wire logic [7:0]              wdata,
	input  wire logic                    wr,
	input  wire logic                    rd,
	output logic [7:0]                   rdata,
	output logic [1:0]                   level,
	output logic                         verify_ok,
	output logic                         program_ok,
	output logic                         table_read_ok,
	output logic                         ext_exec_ok,
	output logic                         ea_eff,
	output logic [7:0]                   verify_data
);
	pml_state_s s_r;
	pml_state_s s_nxt;
	logic       unused;

	// =====================================
	// Map lock pins to a level; odd combos take the level of the set bits counted up from bit one
	function automatic pml_level_e lock_level(input logic b1, input logic b2, input logic b3);
		if (b1 && b2 && b3) begin
			lock_level = PML_LVL_THREE;
		end else if (b1 && b2) begin
			lock_level = PML_LVL_TWO;
		end else if (b1) begin
			lock_level = PML_LVL_ONE;
		end else begin
			lock_level = PML_LVL_OPEN;
		end
	endfunction

	// =====================================
	// Pack the status word from its field positions
	function automatic logic [7:0] status_word(input pml_level_e lvl, input logic ea, input logic enc,
		input logic undef);
		status_word = 8'h00;
		status_word[`PML_ST_LEVEL_LO +: 2] = lvl;
		status_word[`PML_ST_EA_BIT] = ea;
		status_word[`PML_ST_ENC_BIT] = enc;
		status_word[`PML_ST_UNDEF_BIT] = undef;
	endfunction

	assign unused = ^{key_index, fetch_external} | (KEY_DEPTH == 0);

	// =====================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.ea_sync = {s_r.ea_sync[0], external_access_select};
		case (s_r.phase)
			PML_SYNC: begin
				// First flop of the pin synchroniser fills
				s_nxt.phase = PML_SETTLE;
			end
			PML_SETTLE: begin
				// Second flop fills; pin level now trusted
				s_nxt.phase = PML_SAMPLE;
			end
			PML_SAMPLE: begin
				// Capture once after release
				s_nxt.level = lock_level(lock_bit_one, lock_bit_two, lock_bit_three);
				s_nxt.undefined = (lock_bit_three & ~(lock_bit_one & lock_bit_two))
					| (lock_bit_two & ~lock_bit_one);
				s_nxt.enc_on = enc_programmed;
				s_nxt.phase = PML_RUN;
			end
			PML_RUN: begin
				s_nxt.phase = PML_RUN;
			end
			default: begin
				s_nxt.phase = PML_SYNC;
			end
		endcase
		// Pin tracked until capture, then held unless open
		if (s_r.phase != PML_RUN || s_r.level == PML_LVL_OPEN) begin
			s_nxt.ea_lat = s_r.ea_sync[1];
		end
		// Grants derived from the held level
		s_nxt.grant.verify_ok = (s_r.phase == PML_RUN) && (s_r.level < PML_LVL_TWO);
		s_nxt.grant.program_ok = (s_r.phase == PML_RUN) && (s_r.level == PML_LVL_OPEN);
		s_nxt.grant.table_read_ok = (s_r.phase == PML_RUN)
			&& !(s_r.level != PML_LVL_OPEN && fetch_external);
		s_nxt.grant.ext_exec_ok = (s_r.phase == PML_RUN) && (s_r.level != PML_LVL_THREE);
		s_nxt.grant.ea_eff = s_nxt.ea_lat;
		// Verify path; table byte only ever leaves XNORed
		if (s_nxt.grant.verify_ok) begin
			s_nxt.grant.verify_data = s_r.enc_on ? ~(prog_byte ^ key_byte) : prog_byte;
		end else begin
			s_nxt.grant.verify_data = 8'hFF;
		end
		// Register port
		if (wr && addr == `PML_REG_KEYSEL) begin
			s_nxt.keysel = wdata;
		end
		s_nxt.rdata = 8'h00;
		if (rd) begin
			case (addr)
				`PML_REG_STATUS: s_nxt.rdata = status_word(s_r.level, s_r.ea_lat, s_r.enc_on, s_r.undefined);
				`PML_REG_KEYSEL: s_nxt.rdata = s_r.keysel;
				default:         s_nxt.rdata = 8'h00;
			endcase
		end
	end

	// =====================================
	// State register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.keysel <= `PML_KEYSEL_RST;
			s_r.grant.verify_data <= 8'hFF;
		end else begin
			s_r <= s_nxt;
		end
	end

	// =====================================
	// Outputs straight from the state register
	assign rdata         = s_r.rdata;
	assign level         = s_r.level;
	assign verify_ok     = s_r.grant.verify_ok;
	assign program_ok    = s_r.grant.program_ok;
	assign table_read_ok = s_r.grant.table_read_ok;
	assign ext_exec_ok   = s_r.grant.ext_exec_ok;
	assign ea_eff        = s_r.grant.ea_eff;
	assign verify_data   = s_r.grant.verify_data;

	// =====================================
	// Checks
	property p_prog_block;
		@(posedge clock) disable iff (rst) (s_r.level != PML_LVL_OPEN) |=> !program_ok;
	endproperty
	a_prog_block: assert property (p_prog_block) else $error("programming allowed while locked");
	property p_verify_block;
		@(posedge clock) disable iff (rst) (s_r.level >= PML_LVL_TWO) |=> !verify_ok;
	endproperty
	a_verify_block: assert property (p_verify_block) else $error("verify allowed at level two");
	property p_verify_open;
		@(posedge clock) disable iff (rst) (s_r.phase == PML_RUN && s_r.level == PML_LVL_OPEN) |=> verify_ok;
	endproperty
	a_verify_open: assert property (p_verify_open) else $error("verify refused when open");
	property p_exec_block;
		@(posedge clock) disable iff (rst) (s_r.level == PML_LVL_THREE) |=> !ext_exec_ok;
	endproperty
	a_exec_block: assert property (p_exec_block) else $error("external execution allowed");
	property p_table_block;
		@(posedge clock) disable iff (rst) (s_r.level != PML_LVL_OPEN && fetch_external) |=> !table_read_ok;
	endproperty
	a_table_block: assert property (p_table_block) else $error("external table read allowed");
	property p_ea_hold;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_RUN && s_r.level != PML_LVL_OPEN) |=> $stable(s_r.ea_lat);
	endproperty
	a_ea_hold: assert property (p_ea_hold) else $error("access pin latch moved");
	property p_level_hold;
		@(posedge clock) disable iff (rst) (s_r.phase == PML_RUN) |=> $stable(s_r.level) && $stable(s_r.enc_on);
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("lock level changed after sampling");
	property p_enc_data;
		@(posedge clock) disable iff (rst)
			(s_r.enc_on && s_nxt.grant.verify_ok) |=> verify_data == ~($past(prog_byte) ^ $past(key_byte));
	endproperty
	a_enc_data: assert property (p_enc_data) else $error("verify data not encrypted");
	property p_plain_data;
		@(posedge clock) disable iff (rst)
			(!s_r.enc_on && s_nxt.grant.verify_ok) |=> verify_data == $past(prog_byte);
	endproperty
	a_plain_data: assert property (p_plain_data) else $error("plain verify data wrong");

	// =====================================
	// Start-up sequence and sampling
	property p_boot_sync;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_SYNC) |=> (s_r.phase == PML_SETTLE);
	endproperty
	a_boot_sync: assert property (p_boot_sync) else $error("start-up skipped the settle step");
	property p_boot_settle;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_SETTLE) |=> (s_r.phase == PML_SAMPLE);
	endproperty
	a_boot_settle: assert property (p_boot_settle) else $error("start-up skipped the sample step");
	property p_boot_sample;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_SAMPLE) |=> (s_r.phase == PML_RUN);
	endproperty
	a_boot_sample: assert property (p_boot_sample) else $error("sampling repeated");
	property p_run_stays;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_RUN) |=> (s_r.phase == PML_RUN);
	endproperty
	a_run_stays: assert property (p_run_stays) else $error("run phase left without reset");
	property p_lvl_open;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_SAMPLE && !lock_bit_one) |=> (s_r.level == PML_LVL_OPEN);
	endproperty
	a_lvl_open: assert property (p_lvl_open) else $error("open pattern not captured as open");
	property p_lvl_one;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_SAMPLE && lock_bit_one && !lock_bit_two) |=> (s_r.level == PML_LVL_ONE);
	endproperty
	a_lvl_one: assert property (p_lvl_one) else $error("first lock level not captured");
	property p_lvl_two;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_SAMPLE && lock_bit_one && lock_bit_two && !lock_bit_three) |=> (s_r.level == PML_LVL_TWO);
	endproperty
	a_lvl_two: assert property (p_lvl_two) else $error("second lock level not captured");
	property p_lvl_three;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_SAMPLE && lock_bit_one && lock_bit_two && lock_bit_three) |=> (s_r.level == PML_LVL_THREE);
	endproperty
	a_lvl_three: assert property (p_lvl_three) else $error("third lock level not captured");
	property p_sample_enc;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_SAMPLE) |=> (s_r.enc_on == $past(enc_programmed));
	endproperty
	a_sample_enc: assert property (p_sample_enc) else $error("encryption state not captured");
	property p_undef_flag;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_SAMPLE && lock_bit_two && !lock_bit_one) |=> s_r.undefined;
	endproperty
	a_undef_flag: assert property (p_undef_flag) else $error("undefined lock pattern not flagged");
	property p_ea_capture;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_SAMPLE) |=> (s_r.ea_lat == $past(s_r.ea_sync[1]));
	endproperty
	a_ea_capture: assert property (p_ea_capture) else $error("access pin not captured at start");
	property p_ea_follow;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_RUN && s_r.level == PML_LVL_OPEN) |=> (s_r.ea_lat == $past(s_r.ea_sync[1]));
	endproperty
	a_ea_follow: assert property (p_ea_follow) else $error("access pin not followed when open");

	// =====================================
	// Grants
	property p_grant_early;
		@(posedge clock) disable iff (rst)
			(s_r.phase != PML_RUN) |=> (!verify_ok && !program_ok && !table_read_ok && !ext_exec_ok);
	endproperty
	a_grant_early: assert property (p_grant_early) else $error("grant given before sampling");
	property p_table_open;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_RUN && s_r.level == PML_LVL_OPEN) |=> table_read_ok;
	endproperty
	a_table_open: assert property (p_table_open) else $error("table read refused when open");
	property p_table_internal;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_RUN && !fetch_external) |=> table_read_ok;
	endproperty
	a_table_internal: assert property (p_table_internal) else $error("internal table read refused");
	property p_exec_allowed;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_RUN && s_r.level != PML_LVL_THREE) |=> ext_exec_ok;
	endproperty
	a_exec_allowed: assert property (p_exec_allowed) else $error("external execution refused");
	property p_prog_open;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_RUN && s_r.level == PML_LVL_OPEN) |=> program_ok;
	endproperty
	a_prog_open: assert property (p_prog_open) else $error("programming refused when open");
	property p_verify_one;
		@(posedge clock) disable iff (rst)
			(s_r.phase == PML_RUN && s_r.level == PML_LVL_ONE) |=> verify_ok;
	endproperty
	a_verify_one: assert property (p_verify_one) else $error("verify refused at level one");

	// =====================================
	// Verify data
	property p_refused_data;
		@(posedge clock) disable iff (rst)
			(!s_nxt.grant.verify_ok) |=> (verify_data == 8'hFF);
	endproperty
	a_refused_data: assert property (p_refused_data) else $error("data shown while verify refused");
	property p_key_hidden;
		@(posedge clock) disable iff (rst)
			(s_r.enc_on && s_nxt.grant.verify_ok && prog_byte != 8'hFF) |=> (verify_data != $past(key_byte));
	endproperty
	a_key_hidden: assert property (p_key_hidden) else $error("table byte seen on verify data");

	// =====================================
	// Register port
	property p_status_level;
		@(posedge clock) disable iff (rst)
			(rd && addr == `PML_REG_STATUS) |=> (rdata[`PML_ST_LEVEL_LO +: 2] == $past(s_r.level));
	endproperty
	a_status_level: assert property (p_status_level) else $error("status level field wrong");
	property p_status_enc;
		@(posedge clock) disable iff (rst)
			(rd && addr == `PML_REG_STATUS) |=> (rdata[`PML_ST_ENC_BIT] == $past(s_r.enc_on));
	endproperty
	a_status_enc: assert property (p_status_enc) else $error("status encryption bit wrong");
	property p_status_ea;
		@(posedge clock) disable iff (rst)
			(rd && addr == `PML_REG_STATUS) |=> (rdata[`PML_ST_EA_BIT] == $past(s_r.ea_lat));
	endproperty
	a_status_ea: assert property (p_status_ea) else $error("status access pin bit wrong");
endmodule

//--- testbench/pml_prog_model.sv
`timescale 1ns/1ps
// =====================================
// Programmer side: lock pattern and verify bytes
module pml_prog_model (
	input  wire logic       clock,
	input  wire logic [1:0] lvl_req,
	input  wire logic       enc_req,
	output logic            lock_bit_one,
	output logic            lock_bit_two,
	output logic            lock_bit_three,
	output logic            enc_programmed,
	output logic [7:0]      prog_byte,
	output logic [7:0]      key_byte
);
	logic [7:0] cnt_r = 8'h00;
	// Only the four defined lock patterns
	assign lock_bit_one   = lvl_req >= 2'h1;
	assign lock_bit_two   = lvl_req >= 2'h2;
	assign lock_bit_three = lvl_req == 2'h3;
	assign enc_programmed = enc_req;
	// New byte pair every cycle
	always_ff @(posedge clock) begin
		cnt_r <= cnt_r + 8'h01;
	end
	assign prog_byte = cnt_r ^ 8'h96;
	assign key_byte  = {cnt_r[3:0], cnt_r[7:4]};
endmodule

//--- testbench/pml_lock_bench.sv
`timescale 1ns/1ps
`include "pml_params.svh"
// =====================================
// Lock level bench
module pml_lock_bench;
	logic clock, rst, l1, l2, l3, enc_p, ea_pin, fetch_ext, wr, rd, verify_ok, program_ok, table_read_ok;
	logic ext_exec_ok, ea_eff, enc;
	logic [1:0] lvl, level;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, verify_data, prog_byte, key_byte;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	pml_prog_model partner (.clock(clock), .lvl_req(lvl), .enc_req(enc), .lock_bit_one(l1), .lock_bit_two(l2),
		.lock_bit_three(l3), .enc_programmed(enc_p), .prog_byte(prog_byte), .key_byte(key_byte));
	pml_lock dut (.clock(clock), .rst(rst), .lock_bit_one(l1), .lock_bit_two(l2), .lock_bit_three(l3),
		.enc_programmed(enc_p), .external_access_select(ea_pin), .fetch_external(fetch_ext),
		.prog_byte(prog_byte), .key_index(6'h00), .key_byte(key_byte), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .level(level), .verify_ok(verify_ok), .program_ok(program_ok),
		.table_read_ok(table_read_ok), .ext_exec_ok(ext_exec_ok), .ea_eff(ea_eff), .verify_data(verify_data));
	// Clock generator
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task chk(input logic [7:0] s, input logic [7:0] x);
		checked++;
		if (s !== x) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, s, x);
		end
	endtask
	task report_and_stop();
		$display("comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task wr_reg(input logic [3:0] a, input logic [7:0] d);
		addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge clock) wr <= 1'b0;
	endtask
	task rd_reg(input logic [3:0] a, input logic [7:0] x);
		addr <= a; rd <= 1'b1;
		@(posedge clock) rd <= 1'b0;
		@(negedge clock) chk(rdata, x);
		@(posedge clock);
	endtask
	// One reset with a given lock pattern
	task run_case(input logic [1:0] l, input logic e);
		logic [7:0] p, k;
		lvl <= l; enc <= e; ea_pin <= 1'b1; fetch_ext <= 1'b1; rst <= 1'b1;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		repeat (5) @(posedge clock);
		ea_pin <= 1'b0;
		repeat (6) @(posedge clock);
		chk(8'(level), 8'(l));
		chk(8'(verify_ok), 8'(l < 2'h2));
		chk(8'(program_ok), 8'(l == 2'h0));
		chk(8'(ext_exec_ok), 8'(l != 2'h3));
		chk(8'(table_read_ok), 8'(l == 2'h0));
		chk(8'(ea_eff), 8'(l != 2'h0));
		@(negedge clock) begin p = prog_byte; k = key_byte; end
		@(negedge clock) chk(verify_data, l > 2'h1 ? 8'hFF : e ? ~(p ^ k) : p);
		@(posedge clock);
		rd_reg(`PML_REG_STATUS, {4'h0, e, l != 2'h0, l});
		rd_reg(`PML_REG_KEYSEL, `PML_KEYSEL_RST);
		wr_reg(`PML_REG_KEYSEL, 8'hC3);
		rd_reg(`PML_REG_KEYSEL, 8'hC3);
		rd_reg(4'hF, 8'h00);
		fetch_ext <= 1'b0;
		repeat (3) @(posedge clock);
		chk(8'(table_read_ok), 8'h01);
		$display("case level %0d enc %0d done", l, e);
	endtask
	// Timeout watchdog
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			report_and_stop();
		end
	end
	// Main sequence
	initial begin
		rst = 1'b1; lvl = 2'h0; enc = 1'b0; ea_pin = 1'b1; fetch_ext = 1'b0;
		wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00;
		@(posedge clock);
		for (int i = 0; i < 8; i++) run_case(i[2:1], i[0]);
		report_and_stop();
	end
endmodule
